// File: hw/iopf_top.sv
// pin function and per-line settings block for a 32-line group, avalon-mm slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
`include "iopf_cfg.svh"
module iopf_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`IOPF_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [31:0] pad_in,
  output iopf_pkg::iopf_pad_drv_t [31:0] pad_drv,
  input wire iopf_pkg::iopf_periph_drv_t [31:0] periph_drv,
  output logic [31:0] periph_in
);
  // reset release synchroniser, asynchronous assert
  logic rst_s1_q;
  logic rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // bus handshake state
  logic ack_q, ack_d; // second cycle of an access
  logic [31:0] rdata_q, rdata_d; // read data held for the master
  logic req; // any access pending
  logic wr_commit; // write takes effect this edge
  logic [4:0] widx; // word index of the access

  // word indices of the single-word registers, cut to the index width on purpose
  localparam logic [4:0] WIDX_DIR = 5'(`IOPF_OFS_DIR >> 2);
  localparam logic [4:0] WIDX_OUT = 5'(`IOPF_OFS_OUT >> 2);
  localparam logic [4:0] WIDX_IN = 5'(`IOPF_OFS_IN >> 2);
  localparam logic [4:0] WIDX_MPW = 5'(`IOPF_OFS_MPW >> 2);
  logic in_fsel, in_pset; // address range hits

  // configuration storage
  iopf_pkg::iopf_func_t [31:0] func_q, func_d; // one nibble per line
  iopf_pkg::iopf_pin_set_t [31:0] pset_q, pset_d; // settings per line
  logic [31:0] dir_q, dir_d; // port direction, 1 drives
  logic [31:0] out_q, out_d; // port drive value
  logic [31:0] sync1_q, sync2_q; // pad input synchroniser
  logic [31:0] sampled_q, sampled_d; // sampled pin levels
  iopf_pkg::iopf_pad_drv_t [31:0] pad_q, pad_d; // registered pad controls
  logic [31:0] mux_oe, mux_out; // selected peripheral per line

  // multi-pin write fields
  logic mpw_hit, mpw_full;
  logic [`IOPF_MPW_MASK_W-1:0] mpw_mask;
  logic mpw_half_word_select;

  assign req = avs_read | avs_write;
  // one wait cycle: the slave answers on the second edge of every access
  assign avs_waitrequest = req & ~ack_q;
  assign wr_commit = avs_write & ack_q;
  assign widx = avs_address[6:2];
  assign in_fsel = (avs_address >= `IOPF_OFS_FSEL) && (avs_address <= `IOPF_OFS_FSEL_END);
  assign in_pset = (avs_address >= `IOPF_OFS_PSET) && (avs_address <= `IOPF_OFS_PSET_END);
  // the low address bits are ignored, so any byte address inside the word hits
  assign mpw_hit = (widx == WIDX_MPW);
  // partial writes could tear a pin group, so only whole words act
  assign mpw_full = mpw_hit && (avs_byteenable == 4'hf);
  assign mpw_mask = avs_writedata[`IOPF_MPW_MASK_W-1:0];
  assign mpw_half_word_select = avs_writedata[`IOPF_MPW_HALF_WORD_SELECT];
  assign avs_readdata = rdata_q;
  assign pad_drv = pad_q;
  assign periph_in = sampled_q;

  // handshake and read data next values
  always_comb begin
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read && !ack_q) begin
      rdata_d = 32'h0000_0000; // unmapped and write-only words read zero
      if (widx == WIDX_DIR) begin
        rdata_d = dir_q;
      end else if (widx == WIDX_OUT) begin
        rdata_d = out_q;
      end else if (widx == WIDX_IN) begin
        // sampled levels are read only, writes to this word are dropped
        rdata_d = sampled_q;
      end else if (mpw_hit) begin
        rdata_d = 32'h0000_0000;
      end else if (in_fsel) begin
        for (int b = 0; b < 4; b++) begin
          // odd nibble high, even nibble low
          rdata_d[8*b+:8] = {func_q[{avs_address[3:2], 2'(b), 1'b1}],
                             func_q[{avs_address[3:2], 2'(b), 1'b0}]};
        end
      end else if (in_pset) begin
        for (int b = 0; b < 4; b++) begin
          rdata_d[8*b+:8] = {5'h00, pset_q[{avs_address[4:2], 2'(b)}]};
        end
      end
    end
  end

  // register writes, including the atomic multi-pin path
  always_comb begin
    func_d = func_q;
    pset_d = pset_q;
    dir_d = dir_q;
    out_d = out_q;
    if (wr_commit) begin
      if (widx == WIDX_DIR) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            dir_d[8*b+:8] = avs_writedata[8*b+:8];
          end
        end
      end else if (widx == WIDX_OUT) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            out_d[8*b+:8] = avs_writedata[8*b+:8];
          end
        end
      end else if (mpw_full) begin
        for (int i = 0; i < `IOPF_MPW_MASK_W; i++) begin
          // unmasked pins keep their state
          if (mpw_mask[i]) begin
            if (avs_writedata[`IOPF_MPW_APPLY_SET]) begin
              pset_d[{mpw_half_word_select, 4'(i)}] = {avs_writedata[`IOPF_MPW_PULL],
                                            avs_writedata[`IOPF_MPW_INBUF],
                                            avs_writedata[`IOPF_MPW_TAKE]};
            end
            if (avs_writedata[`IOPF_MPW_APPLY_FN]) begin
              func_d[{mpw_half_word_select, 4'(i)}] = avs_writedata[`IOPF_MPW_FN_LSB+:4];
            end
          end
        end
      end else if (in_fsel) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            func_d[{avs_address[3:2], 2'(b), 1'b0}] = avs_writedata[8*b+:4];
            func_d[{avs_address[3:2], 2'(b), 1'b1}] = avs_writedata[8*b+4+:4];
          end
        end
      end else if (in_pset) begin
        for (int b = 0; b < 4; b++) begin
          // reserved upper bits are dropped, they have no storage
          if (avs_byteenable[b]) begin
            pset_d[{avs_address[4:2], 2'(b)}] = avs_writedata[8*b+:`IOPF_SET_W];
          end
        end
      end
    end
  end

  // per-line peripheral selection
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_line
      iopf_pad_mux u_mux (
        .func(func_q[g]),
        .periph(periph_drv[g]),
        .sel_oe(mux_oe[g]),
        .sel_out(mux_out[g])
      );
    end
  endgenerate

  // pad control and sampling next values
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pset_q[i].take) begin
        pad_d[i].oe = mux_oe[i];
        pad_d[i].out = mux_out[i];
      end else begin
        pad_d[i].oe = dir_q[i];
        pad_d[i].out = out_q[i];
      end
      // pull only matters while the pad is an input
      pad_d[i].pull_en = pset_q[i].pull & ~pad_d[i].oe;
      // a disabled buffer reads zero, takeover does not hide the level
      sampled_d[i] = pset_q[i].inbuf ? sync2_q[i] : 1'b0;
    end
  end

  // all state registers except the reset synchroniser
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      func_q <= '{default: `IOPF_FUNC_RST};
      pset_q <= '{default: `IOPF_SET_RST};
      dir_q <= `IOPF_PORT_RST;
      out_q <= `IOPF_PORT_RST;
      sync1_q <= 32'h0000_0000;
      sync2_q <= 32'h0000_0000;
      sampled_q <= 32'h0000_0000;
      pad_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      func_q <= func_d;
      pset_q <= pset_d;
      dir_q <= dir_d;
      out_q <= out_d;
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
      sampled_q <= sampled_d;
      pad_q <= pad_d;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  mask_keep_a: assert property (
    (wr_commit && mpw_full && avs_writedata[`IOPF_MPW_APPLY_SET] && !mpw_half_word_select && !mpw_mask[0])
    |=> (pset_q[0] == $past(pset_q[0])))
    else $error("unmasked pin 0 changed by multi-pin write");
  mpw_rd_zero_a: assert property (
    (avs_read && !avs_waitrequest && mpw_hit) |-> (avs_readdata == 32'h0000_0000))
    else $error("multi-pin register read not zero");
  mpw_partial_a: assert property (
    (wr_commit && mpw_hit && avs_byteenable != 4'hf)
    |=> (pset_q == $past(pset_q)) && (func_q == $past(func_q)))
    else $error("partial multi-pin write had effect");
  pset_rsvd_a: assert property (
    (avs_read && !avs_waitrequest && in_pset)
    |-> ((avs_readdata & `IOPF_PSET_RSVD_MASK) == 32'h0000_0000))
    else $error("reserved settings bits read nonzero");
  port_ctrl_a: assert property (
    (!pset_q[3].take)
    |=> (pad_drv[3].oe == $past(dir_q[3])) && (pad_drv[3].out == $past(out_q[3])))
    else $error("port registers not driving line 3");
  periph_ctrl_a: assert property (
    (pset_q[1].take && func_q[1] == 4'h2)
    |=> (pad_drv[1].oe == $past(periph_drv[1].oe[2]))
        && (pad_drv[1].out == $past(periph_drv[1].out[2])))
    else $error("function c not driving line 1");
  rsvd_code_a: assert property (
    (pset_q[1].take && func_q[1] > `IOPF_FUNC_LAST) |=> !pad_drv[1].oe)
    else $error("reserved code drove line 1");
  inbuf_off_a: assert property (
    (!pset_q[5].inbuf) |=> !periph_in[5])
    else $error("line 5 sampled with buffer off");
  inbuf_on_a: assert property (
    (pset_q[5].inbuf && $stable(pad_in[5]))[*4] |-> (periph_in[5] == pad_in[5]))
    else $error("line 5 level not sampled");
  pull_gate_a: assert property (
    (!pset_q[2].pull) |=> !pad_drv[2].pull_en)
    else $error("pull enabled on line 2 without setting");
  fn_apply_a: assert property (
    (wr_commit && mpw_full && avs_writedata[`IOPF_MPW_APPLY_FN] && mpw_half_word_select && mpw_mask[0])
    |=> (func_q[16] == $past(avs_writedata[27:24])))
    else $error("function code not applied to line 16");
  one_wait_a: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("slave did not answer after one wait cycle");
  reset_clear_a: assert property (
    $rose(rst_sync_n) |-> (pset_q == '0) && (func_q == '0))
    else $error("configuration not cleared by reset");
  // byte lane 0 of the first function word serves lines 0 and 1
  even_fn_a: assert property (
    (wr_commit && in_fsel && avs_address[3:2] == 2'h0 && avs_byteenable[0])
    |=> (func_q[0] == $past(avs_writedata[3:0])))
    else $error("even line 0 function not written");
  odd_fn_a: assert property (
    (wr_commit && in_fsel && avs_address[3:2] == 2'h0 && avs_byteenable[0])
    |=> (func_q[1] == $past(avs_writedata[7:4])))
    else $error("odd line 1 function not written");
  // byte lane 1 of the second settings word belongs to line 5
  pset_wr_a: assert property (
    (wr_commit && in_pset && avs_address[4:2] == 3'h1 && avs_byteenable[1])
    |=> (pset_q[5] == $past(avs_writedata[10:8])))
    else $error("line 5 settings not written");
  set_apply_a: assert property (
    (wr_commit && mpw_full && avs_writedata[`IOPF_MPW_APPLY_SET] && !mpw_half_word_select && mpw_mask[0])
    |=> (pset_q[0] == $past(avs_writedata[18:16])))
    else $error("settings not applied to line 0");
  // an upper-half write must leave every lower line alone
  half_sel_a: assert property (
    (wr_commit && mpw_full && mpw_half_word_select)
    |=> (pset_q[15:0] == $past(pset_q[15:0])) && (func_q[15:0] == $past(func_q[15:0])))
    else $error("upper half write touched lower lines");
  // the level stays readable while a peripheral owns the pad
  pin_visible_a: assert property (
    (pset_q[7].take && pset_q[7].inbuf && $stable(pad_in[7]))[*4]
    |-> (periph_in[7] == pad_in[7]))
    else $error("line 7 level hidden under takeover");

  mpw_apply_c: cover property (wr_commit && mpw_full && avs_writedata[`IOPF_MPW_APPLY_SET]);
  takeover_c: cover property (pset_q[1].take && pad_drv[1].oe);
  pset_read_c: cover property (avs_read && !avs_waitrequest && in_pset);
  rsvd_code_c: cover property (pset_q[1].take && func_q[1] > `IOPF_FUNC_LAST);
  half_sel_c: cover property (wr_commit && mpw_full && mpw_half_word_select && avs_writedata[`IOPF_MPW_APPLY_FN]);
endmodule // iopf_top

// File: hw/iopf_cfg.svh
// register offsets, field positions and reset values of the pin function block
`ifndef IOPF_CFG_SVH
`define IOPF_CFG_SVH

`define IOPF_ADDR_W 7
`define IOPF_OFS_DIR 7'h00
`define IOPF_OFS_OUT 7'h10
`define IOPF_OFS_IN 7'h20
`define IOPF_OFS_MPW 7'h28
`define IOPF_OFS_FSEL 7'h30
`define IOPF_OFS_FSEL_END 7'h3c
`define IOPF_OFS_PSET 7'h40
`define IOPF_OFS_PSET_END 7'h5c

`define IOPF_MPW_HALF_WORD_SELECT 31
`define IOPF_MPW_APPLY_SET 30
`define IOPF_MPW_APPLY_FN 28
`define IOPF_MPW_FN_LSB 24
`define IOPF_MPW_PULL 18
`define IOPF_MPW_INBUF 17
`define IOPF_MPW_TAKE 16
`define IOPF_MPW_MASK_W 16

`define IOPF_SET_W 3
`define IOPF_FUNC_LAST 4'h7
`define IOPF_FUNC_RST 4'h0
`define IOPF_SET_RST 3'h0
`define IOPF_PORT_RST 32'h0000_0000
`define IOPF_PSET_RSVD_MASK 32'hf8f8_f8f8

`endif

// File: hw/iopf_pkg.sv
// types shared by the pin function block
package iopf_pkg;
  // function code of one line, a..h are 0..7
  typedef logic [3:0] iopf_func_t;
  // what the eight candidate peripherals want on one line, bit k is function k
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } iopf_periph_drv_t;
  // what the pad of one line is told to do
  typedef struct packed {
    logic oe;
    logic out;
    logic pull_en;
  } iopf_pad_drv_t;
  // per-line settings, low three bits of the settings byte
  typedef struct packed {
    logic pull;
    logic inbuf;
    logic take;
  } iopf_pin_set_t;
endpackage

// File: hw/iopf_pad_mux.sv
// picks one of eight peripheral drivers for a single line
`timescale 1ns/1ns
`include "iopf_cfg.svh"
module iopf_pad_mux (
  input wire iopf_pkg::iopf_func_t func,
  input wire iopf_pkg::iopf_periph_drv_t periph,
  output logic sel_oe,
  output logic sel_out
);
  // reserved codes leave the pad undriven rather than guess a peripheral
  always_comb begin
    if (func <= `IOPF_FUNC_LAST) begin
      sel_oe = periph.oe[func[2:0]];
      sel_out = periph.out[func[2:0]];
    end else begin
      sel_oe = 1'b0;
      sel_out = 1'b0;
    end
  end
endmodule // iopf_pad_mux

// File: verif/iopf_periph_model.sv
// behavioural on-chip peripherals that compete for the pads
`timescale 1ns/1ns
module iopf_periph_model (
  input wire logic [15:0] pat,
  output iopf_pkg::iopf_periph_drv_t [31:0] periph_drv
);
  // each line and function gets its own level, so a wrong pick shows at the pad
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      periph_drv[i].oe = pat[7:0] ^ 8'(i);
      periph_drv[i].out = pat[15:8] + 8'(i * 3);
    end
  end
endmodule // iopf_periph_model

// File: verif/tb_top.sv
// self-checking bench of the pin function block against a behavioural model
`timescale 1ns/1ns
`include "iopf_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] pad_in = 32'h0;
  logic [15:0] pat = 16'h0;
  logic [31:0] s = 32'hb11ec84d;
  iopf_pkg::iopf_pad_drv_t [31:0] pad_drv;
  iopf_pkg::iopf_periph_drv_t [31:0] periph_drv;
  logic [31:0] periph_in;
  // reference state: function nibbles, settings, direction, drive value
  logic [3:0] m_fn [32] = '{default: 4'h0};
  logic [2:0] m_set [32] = '{default: 3'h0};
  logic [31:0] m_dir = 32'h0;
  logic [31:0] m_out = 32'h0;
  int fail_count = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  iopf_top iopf_top_inst (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .pad_drv(pad_drv),
    .periph_drv(periph_drv), .periph_in(periph_in));
  iopf_periph_model iopf_periph_model_inst (.pat(pat), .periph_drv(periph_drv));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // lines whose input buffer is on
  function automatic logic [31:0] inb();
    for (int i = 0; i < 32; i++) inb[i] = m_set[i][1];
  endfunction

  // expected read value of one word, reserved and unmapped places read zero
  function automatic logic [31:0] exp_rd(input logic [6:0] a);
    logic [31:0] v;
    v = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (a >= `IOPF_OFS_FSEL && a <= `IOPF_OFS_FSEL_END)
        v[8*b+:8] = {m_fn[2*(a-48+b)+1], m_fn[2*(a-48+b)]};
      if (a >= `IOPF_OFS_PSET && a <= `IOPF_OFS_PSET_END)
        v[8*b+:8] = {5'h00, m_set[a-64+b]};
    end
    if (a == `IOPF_OFS_DIR) v = m_dir;
    if (a == `IOPF_OFS_OUT) v = m_out;
    if (a == `IOPF_OFS_IN) v = pad_in & inb();
    return v;
  endfunction

  // one avalon transfer; a clock edge passes first so strobes never toggle twice
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    if (t >= 50) fail_count++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // write and mirror the effect into the reference state
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
    for (int b = 0; b < 4; b++) begin
      if (be[b] && a >= `IOPF_OFS_FSEL && a <= `IOPF_OFS_FSEL_END) begin
        m_fn[2*(a-48+b)] = d[8*b+:4];
        m_fn[2*(a-48+b)+1] = d[8*b+4+:4];
      end
      if (be[b] && a >= `IOPF_OFS_PSET && a <= `IOPF_OFS_PSET_END)
        m_set[a-64+b] = d[8*b+:3];
    end
    if (a == `IOPF_OFS_DIR) m_dir = d;
    if (a == `IOPF_OFS_OUT) m_out = d;
    // only a full-word multi-pin write acts, on masked pins of one half
    if (a == `IOPF_OFS_MPW && be == 4'hf) begin
      for (int i = 0; i < 16; i++) begin
        if (d[i] && d[30]) m_set[i+16*d[31]] = d[18:16];
        if (d[i] && d[28]) m_fn[i+16*d[31]] = d[27:24];
      end
    end
  endtask

  // read every word and compare every pad after things have settled
  task automatic chk_all();
    logic [31:0] q;
    logic [7:0] po;
    logic [7:0] pv;
    logic e_oe;
    logic e_out;
    repeat (5) @(posedge clk);
    for (int a = 0; a < 128; a += 4) begin
      bus(1'b0, 7'(a), 32'h0, 4'hf, q);
      `CHK("readdata", exp_rd(7'(a)), q)
    end
    for (int i = 0; i < 32; i++) begin
      po = pat[7:0] ^ 8'(i);
      pv = pat[15:8] + 8'(i * 3);
      // reserved codes leave the pad undriven
      e_oe = m_set[i][0] ? (m_fn[i] <= 4'h7 && po[m_fn[i][2:0]]) : m_dir[i];
      e_out = m_set[i][0] ? (m_fn[i] <= 4'h7 && pv[m_fn[i][2:0]]) : m_out[i];
      `CHK("pad_drv", {e_oe, e_out, m_set[i][2] & !e_oe}, pad_drv[i])
    end
    `CHK("periph_in", pad_in & inb(), periph_in)
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence: reset values, then random mixes of all write kinds
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_all();
    for (int r = 0; r < 60; r++) begin
      s = lfsr(s);
      pat <= s[15:0];
      pad_in <= {s[7:0], s[31:8]};
      s = lfsr(lfsr(s));
      case (s[2:0])
        3'h0, 3'h1: wr(7'h30 + 7'({s[9:8], 2'b00}), lfsr(s), s[13:10]);
        3'h2: wr(7'h40 + 7'({s[10:8], 2'b00}), lfsr(s), s[14:11]);
        3'h3: wr(`IOPF_OFS_DIR, lfsr(s), 4'hf);
        3'h4: wr(`IOPF_OFS_OUT, lfsr(s), 4'hf);
        3'h7: wr(`IOPF_OFS_MPW, lfsr(s), {1'b0, s[5:3]});
        default: wr(`IOPF_OFS_MPW, lfsr(s), 4'hf);
      endcase
      chk_all();
    end
    give_verdict();
  end

  // watchdog: the run needs well under 20000 cycles
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
endmodule // tb_top
